// ### asp_pkg.sv
/*
  Package for the asynchronous serial port: register offsets, field positions,
  reset values, frame and bit-timing constants, mode and state types.
  Assumes a 32-bit classic Wishbone register bus on the system clock.
*/
package asp_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [3:0] ASP_OFS_CTRL  = 4'h0;
  localparam logic [3:0] ASP_OFS_BUF   = 4'h4;
  localparam logic [3:0] ASP_OFS_BAUD  = 4'h8;

  // ==========================================================================
  // Control register fields
  localparam int ASP_CTRL_MODE_HI = 7;
  localparam int ASP_CTRL_MODE_LO = 6;
  localparam int ASP_CTRL_MP      = 5;
  localparam int ASP_CTRL_REN     = 4;
  localparam int ASP_CTRL_TB8     = 3;
  localparam int ASP_CTRL_RB8     = 2;
  localparam int ASP_CTRL_TI      = 1;
  localparam int ASP_CTRL_RI      = 0;

  // Baud configuration register fields
  localparam int ASP_BAUD_DBL     = 0;
  localparam int ASP_BAUD_SRC     = 1;

  localparam logic [7:0]  ASP_RST_BYTE = 8'h00;
  localparam logic [31:0] ASP_RD_ZERO  = 32'h0000_0000;

  // ==========================================================================
  // Bit timing: 16 oversample ticks per bit, data sampled mid-bit
  localparam logic [3:0] ASP_OS_LAST = 4'hF;
  localparam logic [3:0] ASP_OS_MID  = 4'h7;
  localparam logic [3:0] ASP_DATA_LAST = 4'h7;
  localparam logic [3:0] ASP_NINTH_IDX = 4'h8;
  // Last prescaler count per oversample tick in the fixed-rate mode (2 and 4 clocks, /32 and /64 per bit)
  localparam logic [1:0] ASP_FIX_LAST_DBL = 2'h1;
  localparam logic [1:0] ASP_FIX_LAST_STD = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ASP_MODE_SYNC  = 2'b00,
    ASP_MODE_10T   = 2'b01,
    ASP_MODE_11F   = 2'b10,
    ASP_MODE_11T   = 2'b11
  } asp_mode_t;

  typedef enum logic [2:0] {
    ASP_ST_IDLE  = 3'b000,
    ASP_ST_START = 3'b001,
    ASP_ST_DATA  = 3'b010,
    ASP_ST_NINTH = 3'b011,
    ASP_ST_STOP  = 3'b100
  } asp_state_t;

endpackage : asp_pkg

// ### asp_remote_node.sv
/*
  Remote serial node: drives frames onto the port receive line and captures
  frames from its transmit line. Assumes bit periods given in system clocks.
*/
`timescale 1ns/1ps
module asp_remote_node (
  // Clock
  input  wire logic clk_sys_in,
  // Serial lines
  input  wire logic txd_in,
  output logic      rxd_out
);
  initial rxd_out = 1'b1;

  // ==========================================================================
  // Send start, data LSB first, ninth bit in 11-bit frames, stop
  task automatic send_frame(input logic [7:0] d, input logic b9, input int n, input int bc);
    logic [10:0] fr;
    fr = {1'b1, b9, d, 1'b0};
    if (n == 10) fr[9] = 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys_in);
      rxd_out <= fr[k];
      repeat (bc - 1) @(posedge clk_sys_in);
    end
  endtask : send_frame

  // Capture a frame, sampling each bit in its middle
  task automatic get_frame(input int n, input int bc, output logic [10:0] f);
    f = 11'h7FF;
    do @(posedge clk_sys_in); while (txd_in !== 1'b0);
    repeat (bc / 2) @(posedge clk_sys_in);
    for (int k = 0; k < n; k++) begin
      f[k] = txd_in;
      repeat (bc) @(posedge clk_sys_in);
    end
  endtask : get_frame
endmodule : asp_remote_node

// ### asp_sync.sv
/*
  Two-flop synchroniser for levels entering the system clock domain.
  Assumes nothing but the clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module asp_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : asp_sync

// ### asp_uart.sv
/*
  Asynchronous serial port: 10-bit and 11-bit frame modes, timer or system
  clock bit rate, serial buffer with separate transmit and receive registers,
  classic Wishbone register slave.
  Assumes timer overflow inputs are one-cycle pulses on clk_sys_in and the
  address recognition unit answers combinationally from rx_shift_data_out.
*/
// Chosen here: the register offsets and the Wishbone slave port.
// Functional notes
// - 10-bit frame: start 0, eight data bits LSB first, stop 1, full duplex.
// - 10-bit mode rate from timer overflows; baud doubling bit doubles it on the first port only.
// - Writing the serial buffer sends start, eight data bits, stop at bit rate.
// - Transmit-done flag sets once the stop bit has been driven.
// - With rate running and receive enable set, a falling input edge starts reception.
// - Bits are sampled at the bit rate; acceptance decided mid stop bit.
// - 10-bit accept: rx-done clear and (no multiproc, or stop 1 with match).
// - 10-bit accept loads buffer, stop bit into rx ninth bit, sets rx-done.
// - Rejected character leaves buffer and rx-done unchanged.
// - After each character the receiver watches again for a falling edge.
// - 11-bit frame: start, eight data LSB first, ninth bit, stop.
// - Fixed-rate 11-bit mode runs at system clock /32 or /64 by doubling bit.
// - 11-bit transmit sends data, tx ninth bit, stop, then sets tx-done.
// - 11-bit reception allowed anytime with receive enable; start edge begins it.
// - 11-bit accept: rx-done clear and (no multiproc, or ninth 1 with match).
// - Timer-clocked 11-bit mode equals fixed-rate mode but uses timer overflows.
// - First port picks its timer source by the baud source select bit.
// - Second port always takes its timer rate from the second timer.
// - First port timer rate: overflow rate /32, or /16 when doubled.
// - Source select 0 picks first timer, 1 second timer, timer modes only.
// - Buffer address: writes go to transmit register, reads return receive register.
`timescale 1ns/1ps
module asp_uart
  import asp_pkg::*;
#(
  parameter bit SECOND_PORT = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Bit-rate sources
  input  wire logic        timer1_ovf_in,
  input  wire logic        timer3_ovf_in,
  // Address recognition
  input  wire logic        addr_match_in,
  output logic      [7:0]  rx_shift_data_out,
  // Serial lines
  input  wire logic        rxd_in,
  output logic             txd_out
);

  // ==========================================================================
  // Registers
  asp_mode_t  mode;
  logic       multiproc_enable;
  logic       rx_enable;
  logic       tx_ninth_bit;
  logic       rx_ninth_bit;
  logic       tx_done_flag;
  logic       rx_done_flag;
  logic       baud_double_bit;
  logic       baud_source_select;
  logic [7:0] rx_buffer;

  // ==========================================================================
  // Bus decode
  wire        bus_req    = wb_cyc_in & wb_stb_in;
  wire        bus_wr     = bus_req & wb_we_in & wb_ack_out & wb_sel_in[0];
  wire        hit_ctrl   = (wb_adr_in == ASP_OFS_CTRL);
  wire        hit_buf    = (wb_adr_in == ASP_OFS_BUF);
  wire        hit_baud   = (wb_adr_in == ASP_OFS_BAUD);
  wire        wr_ctrl    = bus_wr & hit_ctrl;
  wire        wr_buf     = bus_wr & hit_buf;
  wire        wr_baud    = bus_wr & hit_baud;
  wire [7:0]  ctrl_rd    = {mode, multiproc_enable, rx_enable, tx_ninth_bit,
                            rx_ninth_bit, tx_done_flag, rx_done_flag};
  wire [7:0]  baud_rd    = {6'b00_0000, baud_source_select, baud_double_bit};
  wire [31:0] next_rdata = hit_ctrl ? {24'h00_0000, ctrl_rd} :
                           hit_buf  ? {24'h00_0000, rx_buffer} :
                           hit_baud ? {24'h00_0000, baud_rd} : ASP_RD_ZERO;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= ASP_RD_ZERO;
    end else begin
      wb_ack_out <= bus_req & ~wb_ack_out;
      if (bus_req & ~wb_ack_out) begin
        wb_dat_out <= next_rdata;
      end
    end
  end

  // ==========================================================================
  // Bit-rate generator: 16 oversample ticks per bit
  wire timer_mode = (mode == ASP_MODE_10T) || (mode == ASP_MODE_11T);
  wire fixed_mode = (mode == ASP_MODE_11F);
  wire active     = timer_mode | fixed_mode;
  wire sel_ovf    = SECOND_PORT ? timer3_ovf_in :
                    (baud_source_select ? timer3_ovf_in : timer1_ovf_in);
  // Timer path: every overflow when doubled or second port, else every other
  wire timer_div1 = SECOND_PORT | baud_double_bit;
  wire [1:0] fix_last = baud_double_bit ? ASP_FIX_LAST_DBL : ASP_FIX_LAST_STD;
  logic [1:0] pre_cnt;
  wire pre_step   = fixed_mode | (timer_mode & sel_ovf);
  wire pre_wrap   = fixed_mode ? (pre_cnt == fix_last) : (timer_div1 | pre_cnt[0]);
  wire os_tick    = pre_step & pre_wrap;
  wire [1:0] next_pre_cnt = !active ? 2'b00 :
                            (pre_step ? (pre_wrap ? 2'b00 : pre_cnt + 2'b01) : pre_cnt);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pre_cnt <= 2'b00;
    end else begin
      pre_cnt <= next_pre_cnt;
    end
  end

  // ==========================================================================
  // Transmitter
  asp_state_t tx_state;
  logic [3:0] tx_os;
  logic [3:0] tx_idx;
  logic [7:0] tx_shift;
  logic       tx_bit9;
  wire        tx_bit_end = os_tick && (tx_os == ASP_OS_LAST);
  wire        tx_start   = wr_buf && active && (tx_state == ASP_ST_IDLE);
  wire        tx_done_ev = tx_bit_end && (tx_state == ASP_ST_STOP);
  asp_state_t next_tx_state;

  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      ASP_ST_IDLE: begin
        if (tx_start) begin
          next_tx_state = ASP_ST_START;
        end
      end
      ASP_ST_START: begin
        if (tx_bit_end) begin
          next_tx_state = ASP_ST_DATA;
        end
      end
      ASP_ST_DATA: begin
        if (tx_bit_end && (tx_idx == ASP_DATA_LAST)) begin
          next_tx_state = (mode == ASP_MODE_10T) ? ASP_ST_STOP : ASP_ST_NINTH;
        end
      end
      ASP_ST_NINTH: begin
        if (tx_bit_end) begin
          next_tx_state = ASP_ST_STOP;
        end
      end
      ASP_ST_STOP: begin
        if (tx_bit_end) begin
          next_tx_state = ASP_ST_IDLE;
        end
      end
      default: next_tx_state = ASP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tx_state <= ASP_ST_IDLE;
      tx_os    <= 4'h0;
      tx_idx   <= 4'h0;
      tx_shift <= ASP_RST_BYTE;
      tx_bit9  <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      if (tx_start) begin
        tx_os    <= 4'h0;
        tx_idx   <= 4'h0;
        tx_shift <= wb_dat_in[7:0];
        tx_bit9  <= tx_ninth_bit;
      end else if (os_tick && (tx_state != ASP_ST_IDLE)) begin
        tx_os <= tx_os + 4'h1;
        if (tx_bit_end && (tx_state == ASP_ST_DATA)) begin
          tx_idx   <= tx_idx + 4'h1;
          tx_shift <= {1'b1, tx_shift[7:1]};
        end
      end
    end
  end

  // Line level registered for a glitch-free output
  wire next_txd = (tx_state == ASP_ST_START) ? 1'b0 :
                  (tx_state == ASP_ST_DATA)  ? tx_shift[0] :
                  (tx_state == ASP_ST_NINTH) ? tx_bit9 : 1'b1;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      txd_out <= 1'b1;
    end else begin
      txd_out <= next_txd;
    end
  end

  // ==========================================================================
  // Receiver
  logic       rxd_sync;
  logic       rxd_prev;
  asp_state_t rx_state;
  logic [3:0] rx_os;
  logic [3:0] rx_idx;
  logic [7:0] rx_shift;
  logic       rx_bit9;

  asp_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_rxd_sync (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .async_in   (rxd_in),
    .sync_out   (rxd_sync)
  );

  wire rx_fall   = rxd_prev & ~rxd_sync;
  wire rx_begin  = (rx_state == ASP_ST_IDLE) && active && rx_enable && rx_fall;
  wire rx_mid    = os_tick && (rx_os == ASP_OS_MID);
  wire rx_bit_end = os_tick && (rx_os == ASP_OS_LAST);
  // Ninth bit is the stop bit in 10-bit mode, else the sampled ninth bit
  wire rx_gate_bit = (mode == ASP_MODE_10T) ? rxd_sync : rx_bit9;
  wire rx_accept = rx_mid && (rx_state == ASP_ST_STOP) && !rx_done_flag &&
                   (!multiproc_enable || (rx_gate_bit && addr_match_in));
  asp_state_t next_rx_state;

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      ASP_ST_IDLE: begin
        if (rx_begin) begin
          next_rx_state = ASP_ST_START;
        end
      end
      ASP_ST_START: begin
        if (rx_mid && rxd_sync) begin
          next_rx_state = ASP_ST_IDLE;
        end else if (rx_bit_end) begin
          next_rx_state = ASP_ST_DATA;
        end
      end
      ASP_ST_DATA: begin
        if (rx_bit_end && (rx_idx == ASP_DATA_LAST)) begin
          next_rx_state = (mode == ASP_MODE_10T) ? ASP_ST_STOP : ASP_ST_NINTH;
        end
      end
      ASP_ST_NINTH: begin
        if (rx_bit_end) begin
          next_rx_state = ASP_ST_STOP;
        end
      end
      ASP_ST_STOP: begin
        if (rx_mid) begin
          next_rx_state = ASP_ST_IDLE;
        end
      end
      default: next_rx_state = ASP_ST_IDLE;
    endcase
    if (!active) begin
      next_rx_state = ASP_ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rxd_prev <= 1'b1;
      rx_state <= ASP_ST_IDLE;
      rx_os    <= 4'h0;
      rx_idx   <= 4'h0;
      rx_shift <= ASP_RST_BYTE;
      rx_bit9  <= 1'b0;
    end else begin
      rxd_prev <= rxd_sync;
      rx_state <= next_rx_state;
      if (rx_begin) begin
        rx_os  <= 4'h0;
        rx_idx <= 4'h0;
      end else if (os_tick && (rx_state != ASP_ST_IDLE)) begin
        rx_os <= rx_os + 4'h1;
        if (rx_bit_end && (rx_state == ASP_ST_DATA)) begin
          rx_idx <= rx_idx + 4'h1;
        end
        if (rx_mid && (rx_state == ASP_ST_DATA)) begin
          rx_shift <= {rxd_sync, rx_shift[7:1]};
        end
        if (rx_mid && (rx_state == ASP_ST_NINTH)) begin
          rx_bit9 <= rxd_sync;
        end
      end
    end
  end

  assign rx_shift_data_out = rx_shift;

  // ==========================================================================
  // Software registers and flags; hardware set wins over a software clear
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mode               <= ASP_MODE_SYNC;
      multiproc_enable   <= 1'b0;
      rx_enable          <= 1'b0;
      tx_ninth_bit       <= 1'b0;
      rx_ninth_bit       <= 1'b0;
      tx_done_flag       <= 1'b0;
      rx_done_flag       <= 1'b0;
      baud_double_bit    <= 1'b0;
      baud_source_select <= 1'b0;
      rx_buffer          <= ASP_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        mode             <= asp_mode_t'(wb_dat_in[ASP_CTRL_MODE_HI:ASP_CTRL_MODE_LO]);
        multiproc_enable <= wb_dat_in[ASP_CTRL_MP];
        rx_enable        <= wb_dat_in[ASP_CTRL_REN];
        tx_ninth_bit     <= wb_dat_in[ASP_CTRL_TB8];
        rx_ninth_bit     <= wb_dat_in[ASP_CTRL_RB8];
        tx_done_flag     <= wb_dat_in[ASP_CTRL_TI];
        rx_done_flag     <= wb_dat_in[ASP_CTRL_RI];
      end
      if (wr_baud) begin
        baud_double_bit    <= wb_dat_in[ASP_BAUD_DBL];
        baud_source_select <= wb_dat_in[ASP_BAUD_SRC];
      end
      if (tx_done_ev) begin
        tx_done_flag <= 1'b1;
      end
      if (rx_accept) begin
        rx_buffer    <= rx_shift;
        rx_ninth_bit <= rx_gate_bit;
        rx_done_flag <= 1'b1;
      end
    end
  end

endmodule : asp_uart

// ### asp_uart_assertions.sv
/*
  Checker for asp_uart: bus answer timing, read data and transmit line timing.
  Assumes it sees the ports of every asp_uart instance through the bind below.
*/
`timescale 1ns/1ps
module asp_uart_assertions
  import asp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Wishbone
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_out,
  input  wire logic        wb_ack_out,
  // Serial output
  input  wire logic        txd_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  // ==========================================================================
  // Helpers
  wire  req_w   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire  unmap_w = (wb_adr_in != ASP_OFS_CTRL) && (wb_adr_in != ASP_OFS_BUF) && (wb_adr_in != ASP_OFS_BAUD);
  wire  bufwr_w = req_w && wb_we_in && wb_sel_in[0] && (wb_adr_in == ASP_OFS_BUF);
  logic wrote;
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) wrote <= 1'b0;
    else if (bufwr_w) wrote <= 1'b1;
  end

  sequence s_req;
    req_w;
  endsequence
  sequence s_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  // ==========================================================================
  // Properties
  a_ack_pulse: assert property (s_req |=> s_pulse)
    else $error("ack not a single pulse one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(req_w))
    else $error("ack without request");
  a_rdata_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (req_w && !wb_we_in && unmap_w |=> wb_dat_out == ASP_RD_ZERO)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!req_w && !wb_ack_out |-> $stable(wb_dat_out))
    else $error("read data changed without request");
  a_txd_low_min: assert property ($fell(txd_out) |-> !txd_out [*8])
    else $error("low bit shorter than minimum");
  a_txd_high_min: assert property ($rose(txd_out) |-> txd_out [*8])
    else $error("high bit shorter than minimum");
  a_tx_idle_first: assert property (!wrote |-> txd_out)
    else $error("transmit line active without buffer write");
endmodule : asp_uart_assertions

bind asp_uart asp_uart_assertions u_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .txd_out(txd_out)
);

// ### asp_uart_test.sv
/*
  Self-checking bench for asp_uart: async modes, rate sources, full duplex,
  acceptance and rejection. Assumes the remote node model on the serial lines.
*/
`timescale 1ns/1ps
module asp_uart_test;
  import asp_pkg::*;
  localparam logic [13:0] MODES = {2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  localparam logic [6:0]  DBLS  = 7'h52;
  localparam logic [6:0]  SRCS  = 7'h44;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic        wb_cyc_in  = 1'b0;
  logic        wb_stb_in  = 1'b0;
  logic        wb_we_in   = 1'b0;
  logic [3:0]  wb_adr_in  = 4'h0;
  logic [3:0]  wb_sel_in  = 4'h0;
  logic [31:0] wb_dat_in  = 32'h0000_0000;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        timer1_ovf_in = 1'b0;
  logic        timer3_ovf_in = 1'b0;
  logic        addr_match_in = 1'b0;
  logic [1:0]  ovf_cnt       = 2'h0;
  logic        rxd_w;
  logic        txd_w;
  logic [7:0]  rx_sh_w;
  int          mismatches = 0;
  int          compares   = 0;
  int          seed_v;

  always #50 clk_sys_in = ~clk_sys_in;
  // Timer 1 overflows every 2 clocks, timer 3 every 3 clocks
  always @(posedge clk_sys_in) begin
    timer1_ovf_in <= ~timer1_ovf_in;
    ovf_cnt       <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
    timer3_ovf_in <= (ovf_cnt == 2'h2);
  end

  asp_uart dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .timer1_ovf_in(timer1_ovf_in),
    .timer3_ovf_in(timer3_ovf_in), .addr_match_in(addr_match_in), .rx_shift_data_out(rx_sh_w),
    .rxd_in(rxd_w), .txd_out(txd_w));
  asp_remote_node node (.clk_sys_in(clk_sys_in), .txd_in(txd_w), .rxd_out(rxd_w));

  // ==========================================================================
  // Expectations
  function automatic int bitclk(input logic [1:0] m, input logic d, input logic s);
    if (m == 2'h2 || !s) return d ? 32 : 64;
    return d ? 48 : 96;
  endfunction : bitclk

  function automatic logic [31:0] exp_frame(input logic [7:0] d, input logic b9, input int n);
    return {21'h00_0000, 1'b1, (n == 11) ? b9 : 1'b1, d, 1'b0};
  endfunction : exp_frame

  // ==========================================================================
  // Bus and reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_sel_in <= 4'hF;
    wb_dat_in <= dat;
    do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0000_0000, v);
    check(v, exp);
  endtask : rd_chk

  task automatic final_report();
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    repeat (90000) @(posedge clk_sys_in);
    mismatches++;
    final_report();
  end

  initial begin
    logic [31:0] v;
    logic [10:0] f;
    logic [7:0]  a, b;
    logic [1:0]  m;
    logic        t8, nb;
    int          n, bc;
    seed_v = $urandom(98);
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd_chk(ASP_OFS_CTRL, ASP_RD_ZERO);
    rd_chk(ASP_OFS_BUF, ASP_RD_ZERO);
    rd_chk(ASP_OFS_BAUD, ASP_RD_ZERO);
    wb(1'b1, 4'hC, 32'h0000_00FF, v);
    rd_chk(4'hC, ASP_RD_ZERO);
    // Synchronous mode is not built: a buffer write must leave the line idle
    wb(1'b1, ASP_OFS_BUF, 32'h0000_00A5, v);
    repeat (64) @(posedge clk_sys_in);
    check(32'(txd_w), 32'h0000_0001);
    rd_chk(ASP_OFS_CTRL, ASP_RD_ZERO);
    for (int i = 0; i < 7; i++) begin
      m  = MODES[2*i +: 2];
      n  = (m == ASP_MODE_10T) ? 10 : 11;
      bc = bitclk(m, DBLS[i], SRCS[i]);
      t8 = 1'($urandom);
      nb = (n == 11) ? 1'($urandom) : 1'b1;
      a  = 8'($urandom);
      b  = 8'($urandom);
      addr_match_in <= 1'b0;
      wb(1'b1, ASP_OFS_BAUD, {30'h0000_0000, SRCS[i], DBLS[i]}, v);
      wb(1'b1, ASP_OFS_CTRL, {24'h00_0000, m, 1'b0, 1'b1, t8, 3'h0}, v);
      fork
        begin
          wb(1'b1, ASP_OFS_BUF, {24'h00_0000, a}, v);
          node.get_frame(n, bc, f);
          check({21'h00_0000, f}, exp_frame(a, t8, n));
          for (int k = 0; k < 40 && v[1] !== 1'b1; k++) wb(1'b0, ASP_OFS_CTRL, 32'h0000_0000, v);
        end
        node.send_frame(b, nb, n, bc);
      join
      rd_chk(ASP_OFS_CTRL, {24'h00_0000, m, 1'b0, 1'b1, t8, nb, 2'h3});
      rd_chk(ASP_OFS_BUF, {24'h00_0000, b});
      // Receive-done still set: character is dropped
      node.send_frame(a, 1'b1, n, bc);
      rd_chk(ASP_OFS_BUF, {24'h00_0000, b});
      // Multiprocessor gate failing: no match in 10-bit, ninth bit 0 in 11-bit
      wb(1'b1, ASP_OFS_CTRL, {24'h00_0000, m, 1'b1, 1'b1, t8, 3'h0}, v);
      addr_match_in <= (n == 11);
      node.send_frame(a, (n == 10), n, bc);
      rd_chk(ASP_OFS_CTRL, {24'h00_0000, m, 1'b1, 1'b1, t8, 3'h0});
      rd_chk(ASP_OFS_BUF, {24'h00_0000, b});
      // Address unit sees the shifted-in byte even when it is rejected
      check(32'(rx_sh_w), 32'(a));
      addr_match_in <= 1'b1;
      node.send_frame(a, 1'b1, n, bc);
      rd_chk(ASP_OFS_CTRL, {24'h00_0000, m, 1'b1, 1'b1, t8, 3'h5});
      rd_chk(ASP_OFS_BUF, {24'h00_0000, a});
    end
    final_report();
  end
endmodule : asp_uart_test
